// file: common/adt_defines.svh
// Register map, field positions, reset values and limits of the analog differential trigger.
`ifndef ADT_DEFINES_SVH
`define ADT_DEFINES_SVH

// ----------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------
`define ADT_AW            4
`define ADT_DW            32
`define ADT_REG_CTRL      4'h0
`define ADT_REG_GAIN      4'h1
`define ADT_REG_OFFSET    4'h2
`define ADT_REG_ON        4'h3
`define ADT_REG_DELTA     4'h4
`define ADT_REG_DECIMALS  4'h5
`define ADT_REG_SOURCE    4'h6
`define ADT_REG_PERIOD    4'h7
`define ADT_REG_STATUS    4'h8
`define ADT_REG_WORK      4'h9
`define ADT_REG_OFF       4'hA

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADT_CTRL_EN_BIT   0
`define ADT_SRC_KIND_LSB  0
`define ADT_SRC_IDX_LSB   8
`define ADT_STAT_Q_BIT    0
`define ADT_STAT_WIN_BIT  1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADT_CTRL_EN_RST   1'h1
`define ADT_GAIN_RST      16'sh0064
`define ADT_PERIOD_RST    16'h0032

// ----------------------------------------------------------------
// Limits and scaling
// ----------------------------------------------------------------
`define ADT_GAIN_LIM      32'sh000003E8
`define ADT_OFFSET_LIM    32'sh00002710
`define ADT_THR_LIM       32'sh00004E20
`define ADT_DEC_MAX       32'sh00000003
`define ADT_SENSOR_MAX    10'h3E8
`define ADT_GAIN_SCALE    32'sh00000064
`define ADT_SENSOR_W      10
`define ADT_VAL_W         16

`endif

// file: common/adt_pkg.sv
// Types and helpers shared by the analog differential trigger modules.
package adt_pkg;

	typedef enum logic [2:0] {
		adt_src_sensor,
		adt_src_flag,
		adt_src_net_in,
		adt_src_aout,
		adt_src_net_out,
		adt_src_block
	} adt_src_t;

	// Saturates a written value to the symmetric range of its setting.
	function automatic logic signed [15:0] adt_clamp(input logic signed [31:0] v, input logic signed [31:0] lim);
		logic signed [31:0] r;
		r = v;
		if (v > lim) begin
			r = lim;
		end else if (v < -lim) begin
			r = -lim;
		end
		return r[15:0];
	endfunction : adt_clamp

endpackage : adt_pkg

// file: sim/adt_source_model.sv
// Behavioural model of the analog sources that feed the trigger.
`timescale 1ns/10ps
`include "adt_defines.svh"
module adt_source_model (
	output logic [8*`ADT_SENSOR_W-1:0]  o_sensor_voltage_inputs,
	output logic [16*`ADT_VAL_W-1:0]    o_analog_flags,
	output logic [32*`ADT_VAL_W-1:0]    o_network_inputs,
	output logic [2*`ADT_VAL_W-1:0]     o_analog_outputs,
	output logic [16*`ADT_VAL_W-1:0]    o_network_outputs,
	output logic [`ADT_VAL_W-1:0]       o_block_value
);
	// Values start at zero by declaration so that set_val is the only writer.
	logic [`ADT_SENSOR_W-1:0] sensor_ff [8]  = '{default: '0};
	logic [`ADT_VAL_W-1:0]    flag_ff   [16] = '{default: '0};
	logic [`ADT_VAL_W-1:0]    netin_ff  [32] = '{default: '0};
	logic [`ADT_VAL_W-1:0]    aout_ff   [2]  = '{default: '0};
	logic [`ADT_VAL_W-1:0]    netout_ff [16] = '{default: '0};
	logic [`ADT_VAL_W-1:0]    blk_ff         = 16'h0000;

	// Sets one source value; called by the bench just after a rising clock edge.
	task automatic set_val(input int kind, input int idx, input logic [15:0] val);
		case (kind)
			0: sensor_ff[idx] <= val[9:0];
			1: flag_ff[idx] <= val;
			2: netin_ff[idx] <= val;
			3: aout_ff[idx] <= val;
			4: netout_ff[idx] <= val;
			default: blk_ff <= val;
		endcase
	endtask : set_val

	always_comb begin
		for (int n = 0; n < 8; n++) o_sensor_voltage_inputs[10*n +: 10] = sensor_ff[n];
		for (int n = 0; n < 16; n++) o_analog_flags[16*n +: 16] = flag_ff[n];
		for (int n = 0; n < 32; n++) o_network_inputs[16*n +: 16] = netin_ff[n];
		for (int n = 0; n < 2; n++) o_analog_outputs[16*n +: 16] = aout_ff[n];
		for (int n = 0; n < 16; n++) o_network_outputs[16*n +: 16] = netout_ff[n];
		o_block_value = blk_ff;
	end
endmodule : adt_source_model

// file: sim/adt_trigger_tb.sv
// Self-checking testbench of the analog differential trigger.
`timescale 1ns/10ps
`include "adt_defines.svh"
module adt_trigger_tb;
	logic                           i_mclk;
	logic                           i_rst_b;
	logic [`ADT_AW-1:0]             i_addr;
	logic [`ADT_DW-1:0]             i_wdata;
	logic                           i_wr;
	logic                           i_rd;
	logic [`ADT_DW-1:0]             o_rdata;
	logic                           o_q;
	logic [8*`ADT_SENSOR_W-1:0]     sens;
	logic [16*`ADT_VAL_W-1:0]       flags;
	logic [32*`ADT_VAL_W-1:0]       netin;
	logic [2*`ADT_VAL_W-1:0]        aout;
	logic [16*`ADT_VAL_W-1:0]       netout;
	logic [`ADT_VAL_W-1:0]          blk;
	int                             fail_count;
	int                             n_compared;
	int                             cycles;

	adt_source_model u_src (
		.o_sensor_voltage_inputs (sens),
		.o_analog_flags          (flags),
		.o_network_inputs        (netin),
		.o_analog_outputs        (aout),
		.o_network_outputs       (netout),
		.o_block_value           (blk)
	);

	adt_trigger u_dut (
		.i_mclk                  (i_mclk),
		.i_rst_b                 (i_rst_b),
		.i_addr                  (i_addr),
		.i_wdata                 (i_wdata),
		.i_wr                    (i_wr),
		.i_rd                    (i_rd),
		.o_rdata                 (o_rdata),
		.i_sensor_voltage_inputs (sens),
		.i_analog_flags          (flags),
		.i_network_inputs        (netin),
		.i_analog_outputs        (aout),
		.i_network_outputs       (netout),
		.i_block_value           (blk),
		.o_q                     (o_q)
	);

	initial i_mclk = 1'b0;
	always #10 i_mclk = ~i_mclk;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic final_report();
		$display("Comparisons: %0d, mismatches: %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	task automatic chk_reg(input logic [3:0] a, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %0t register %0d read %h expected %h", $time, a, got, exp);
		end
	endtask : chk_reg

	task automatic chk_q(input logic exp);
		n_compared++;
		if (o_q !== exp) begin
			fail_count++;
			$display("FAIL %0t output %b expected %b", $time, o_q, exp);
		end
	endtask : chk_q

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge i_mclk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd   <= 1'b0;
		#1;
		chk_reg(a, o_rdata, exp);
	endtask : rd

	// Sets one source value, lets several program cycles pass, then checks the output.
	task automatic step(input int kind, input int idx, input logic [15:0] v, input logic exp);
		@(posedge i_mclk);
		u_src.set_val(kind, idx, v);
		repeat (8) @(posedge i_mclk);
		#1;
		chk_q(exp);
	endtask : step

	task automatic cfg(input logic [31:0] g, input logic [31:0] ofs, input logic [31:0] on, input logic [31:0] dl);
		wr(`ADT_REG_GAIN, g);
		wr(`ADT_REG_OFFSET, ofs);
		wr(`ADT_REG_ON, on);
		wr(`ADT_REG_DELTA, dl);
	endtask : cfg

	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		i_rst_b = 1'b0;
		i_addr = 4'h0;
		i_wdata = 32'h00000000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		fail_count = 0;
		n_compared = 0;
		cycles = 0;
		repeat (12) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		#1;
		chk_q(1'b0);
		rd(`ADT_REG_GAIN, 32'h00000064);
		rd(`ADT_REG_PERIOD, 32'h00000032);
		rd(`ADT_REG_CTRL, 32'h00000001);
		rd(4'hB, 32'h00000000);
		wr(`ADT_REG_GAIN, 32'h000007D0);
		rd(`ADT_REG_GAIN, 32'h000003E8);
		wr(`ADT_REG_OFFSET, 32'h00004E20);
		rd(`ADT_REG_OFFSET, 32'h00002710);
		wr(`ADT_REG_ON, 32'hFFFF8AD0);
		rd(`ADT_REG_ON, 32'hFFFFB1E0);
		wr(`ADT_REG_DELTA, 32'h00007530);
		rd(`ADT_REG_DELTA, 32'h00004E20);
		wr(`ADT_REG_DECIMALS, 32'hFFFFFFFF);
		rd(`ADT_REG_DECIMALS, 32'h00000000);
		wr(`ADT_REG_DECIMALS, 32'h00000007);
		rd(`ADT_REG_DECIMALS, 32'h00000003);
		wr(`ADT_REG_PERIOD, 32'h00000002);
		// Hysteresis: switch at 500, release at 400.
		cfg(32'h00000064, 32'h00000000, 32'h000001F4, 32'hFFFFFF9C);
		rd(`ADT_REG_OFF, 32'h00000190);
		step(0, 0, 16'h01F4, 1'b0);
		rd(`ADT_REG_WORK, 32'h0000C350);
		step(0, 0, 16'h01F5, 1'b1);
		step(0, 0, 16'h01C2, 1'b1);
		step(0, 0, 16'h0190, 1'b0);
		step(0, 0, 16'h01C2, 1'b0);
		// Window: high from 500 up to below 600; decimals stay at 3.
		wr(`ADT_REG_DELTA, 32'h00000064);
		step(0, 0, 16'h01F4, 1'b1);
		rd(`ADT_REG_STATUS, 32'h00000003);
		step(0, 0, 16'h0257, 1'b1);
		step(0, 0, 16'h0258, 1'b0);
		step(0, 0, 16'h01F3, 1'b0);
		// Negative gain with offset, value from an analog flag.
		wr(`ADT_REG_SOURCE, 32'h00000301);
		rd(`ADT_REG_SOURCE, 32'h00000301);
		cfg(32'hFFFFFF38, 32'h000005DC, 32'h00000640, 32'hFFFFFFCE);
		step(1, 3, 16'hFF9C, 1'b1);
		step(1, 3, 16'h0064, 1'b0);
		rd(`ADT_REG_WORK, 32'h0001FBD0);
		// Sensor reading above full scale is held at 1000.
		wr(`ADT_REG_SOURCE, 32'h00000000);
		cfg(32'h00000064, 32'h00000000, 32'h000003E7, 32'hFFFFFFFF);
		step(0, 0, 16'h03FF, 1'b1);
		rd(`ADT_REG_WORK, 32'h000186A0);
		// Every kind of source, entry 1 of each group.
		cfg(32'h00000064, 32'h00000000, 32'h00000258, 32'hFFFFFF9C);
		for (int k = 0; k < 6; k++) begin
			wr(`ADT_REG_SOURCE, 32'h00000100 | k);
			step(k, 1, 16'h02BC, 1'b1);
			step(k, 1, 16'h0000, 1'b0);
		end
		// Disabling clears the output.
		step(5, 1, 16'h02BC, 1'b1);
		wr(`ADT_REG_CTRL, 32'h00000000);
		step(5, 1, 16'h02BC, 1'b0);
		// Source kinds beyond the block value give zero.
		wr(`ADT_REG_CTRL, 32'h00000001);
		step(5, 1, 16'h02BC, 1'b1);
		wr(`ADT_REG_SOURCE, 32'h00000106);
		rd(`ADT_REG_SOURCE, 32'h00000106);
		step(5, 1, 16'h02BC, 1'b0);
		// Reset in mid-run with the output high.
		wr(`ADT_REG_SOURCE, 32'h00000105);
		step(5, 1, 16'h02BC, 1'b1);
		@(posedge i_mclk);
		i_rst_b <= 1'b0;
		#1;
		chk_q(1'b0);
		repeat (2) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		rd(`ADT_REG_GAIN, 32'h00000064);
		rd(`ADT_REG_SOURCE, 32'h00000000);
		chk_q(1'b0);
		// Sensor 0 still reads full scale, so the first program cycle sets the output.
		repeat (60) @(posedge i_mclk);
		#1;
		chk_q(1'b1);
		final_report();
	end
endmodule : adt_trigger_tb

// file: verilog/adt_scale.sv
// Gain and offset scaling of the selected analog value, in hundredths.
`timescale 1ns/10ps
`include "adt_defines.svh"
module adt_scale
	import adt_pkg::*;
(
	input  wire logic signed [15:0] i_x,
	input  wire logic signed [15:0] i_gain,
	input  wire logic signed [15:0] i_offset,
	output logic signed      [31:0] o_work
);

	// The gain holds hundredths, so the offset is lifted by the same factor and no fraction is lost.
	always_comb begin
		o_work = 32'(i_x) * 32'(i_gain) + 32'(i_offset) * `ADT_GAIN_SCALE;
	end

endmodule : adt_scale

// file: verilog/adt_trigger.sv
// Analog differential trigger: source select, scaling, hysteresis or window switch, registers.
`timescale 1ns/10ps
`include "adt_defines.svh"
module adt_trigger
	import adt_pkg::*;
(
	input  wire logic                      i_mclk,
	input  wire logic                      i_rst_b,
	input  wire logic [`ADT_AW-1:0]        i_addr,
	input  wire logic [`ADT_DW-1:0]        i_wdata,
	input  wire logic                      i_wr,
	input  wire logic                      i_rd,
	output logic      [`ADT_DW-1:0]        o_rdata,
	input  wire logic [8*`ADT_SENSOR_W-1:0] i_sensor_voltage_inputs,
	input  wire logic [16*`ADT_VAL_W-1:0]  i_analog_flags,
	input  wire logic [32*`ADT_VAL_W-1:0]  i_network_inputs,
	input  wire logic [2*`ADT_VAL_W-1:0]   i_analog_outputs,
	input  wire logic [16*`ADT_VAL_W-1:0]  i_network_outputs,
	input  wire logic [`ADT_VAL_W-1:0]     i_block_value,
	output logic                           o_q
);

	// ----------------------------------------------------------------
	// Settings registers
	// ----------------------------------------------------------------
	logic               en_ff,       nxt_en;
	logic signed [15:0] gain_ff,     nxt_gain;
	logic signed [15:0] offset_ff,   nxt_offset;
	logic signed [15:0] on_ff,       nxt_on;
	logic signed [15:0] delta_ff,    nxt_delta;
	logic        [1:0]  dec_ff,      nxt_dec;
	logic        [2:0]  src_kind_ff, nxt_src_kind;
	logic        [4:0]  src_idx_ff,  nxt_src_idx;
	logic        [15:0] period_ff,   nxt_period;

	always_comb begin
		nxt_en       = en_ff;
		nxt_gain     = gain_ff;
		nxt_offset   = offset_ff;
		nxt_on       = on_ff;
		nxt_delta    = delta_ff;
		nxt_dec      = dec_ff;
		nxt_src_kind = src_kind_ff;
		nxt_src_idx  = src_idx_ff;
		nxt_period   = period_ff;
		if (i_wr) begin
			unique case (i_addr)
				`ADT_REG_CTRL:     nxt_en = i_wdata[`ADT_CTRL_EN_BIT];
				`ADT_REG_GAIN:     nxt_gain = adt_clamp(i_wdata, `ADT_GAIN_LIM);
				`ADT_REG_OFFSET:   nxt_offset = adt_clamp(i_wdata, `ADT_OFFSET_LIM);
				`ADT_REG_ON:       nxt_on = adt_clamp(i_wdata, `ADT_THR_LIM);
				`ADT_REG_DELTA:    nxt_delta = adt_clamp(i_wdata, `ADT_THR_LIM);
				`ADT_REG_DECIMALS: begin
					if ($signed(i_wdata) > `ADT_DEC_MAX) begin
						nxt_dec = 2'h3;
					end else if ($signed(i_wdata) < 32'sh00000000) begin
						nxt_dec = 2'h0;
					end else begin
						nxt_dec = i_wdata[1:0];
					end
				end
				`ADT_REG_SOURCE: begin
					nxt_src_kind = i_wdata[`ADT_SRC_KIND_LSB +: 3];
					nxt_src_idx  = i_wdata[`ADT_SRC_IDX_LSB +: 5];
				end
				`ADT_REG_PERIOD:   nxt_period = i_wdata[15:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			en_ff       <= `ADT_CTRL_EN_RST;
			gain_ff     <= `ADT_GAIN_RST;
			offset_ff   <= 16'sh0000;
			on_ff       <= 16'sh0000;
			delta_ff    <= 16'sh0000;
			dec_ff      <= 2'h0;
			src_kind_ff <= 3'h0;
			src_idx_ff  <= 5'h00;
			period_ff   <= `ADT_PERIOD_RST;
		end else begin
			en_ff       <= nxt_en;
			gain_ff     <= nxt_gain;
			offset_ff   <= nxt_offset;
			on_ff       <= nxt_on;
			delta_ff    <= nxt_delta;
			dec_ff      <= nxt_dec;
			src_kind_ff <= nxt_src_kind;
			src_idx_ff  <= nxt_src_idx;
			period_ff   <= nxt_period;
		end
	end

	// ----------------------------------------------------------------
	// Source selection
	// ----------------------------------------------------------------
	logic signed [15:0] sel_x;
	logic        [9:0]  sensor_raw;

	// The index wraps to the size of each source group.
	always_comb begin
		sensor_raw = i_sensor_voltage_inputs[src_idx_ff[2:0]*`ADT_SENSOR_W +: `ADT_SENSOR_W];
		sel_x      = 16'sh0000;
		case (adt_src_t'(src_kind_ff))
			adt_src_sensor: begin
				sel_x = (sensor_raw > `ADT_SENSOR_MAX) ? 16'sh03E8 : $signed({6'h00, sensor_raw});
			end
			adt_src_flag:    sel_x = i_analog_flags[src_idx_ff[3:0]*`ADT_VAL_W +: `ADT_VAL_W];
			adt_src_net_in:  sel_x = i_network_inputs[src_idx_ff*`ADT_VAL_W +: `ADT_VAL_W];
			adt_src_aout:    sel_x = i_analog_outputs[src_idx_ff[0]*`ADT_VAL_W +: `ADT_VAL_W];
			adt_src_net_out: sel_x = i_network_outputs[src_idx_ff[3:0]*`ADT_VAL_W +: `ADT_VAL_W];
			adt_src_block:   sel_x = i_block_value;
			default:         sel_x = 16'sh0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Scaling and thresholds
	// ----------------------------------------------------------------
	logic signed [31:0] work;
	logic signed [31:0] on_x100;
	logic signed [31:0] off_thr;
	logic signed [31:0] off_x100;
	logic               win_mode;

	adt_scale u_scale (
		.i_x      (sel_x),
		.i_gain   (gain_ff),
		.i_offset (offset_ff),
		.o_work   (work)
	);

	// Thresholds are compared in hundredths so the scaled value needs no division.
	always_comb begin
		off_thr  = 32'(on_ff) + 32'(delta_ff);
		on_x100  = 32'(on_ff) * `ADT_GAIN_SCALE;
		off_x100 = off_thr * `ADT_GAIN_SCALE;
		win_mode = (delta_ff > 16'sh0000);
	end

	// ----------------------------------------------------------------
	// Program cycle divider
	// ----------------------------------------------------------------
	logic [15:0] cnt_ff, nxt_cnt;
	logic        tick_ff, nxt_tick;
	logic [15:0] period_eff;

	always_comb begin
		period_eff = (period_ff == 16'h0000) ? 16'h0001 : period_ff;
		nxt_cnt    = 16'h0000;
		nxt_tick   = 1'b0;
		if (en_ff) begin
			if (cnt_ff >= period_eff - 16'h0001) begin
				nxt_tick = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_ff  <= 16'h0000;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	// ----------------------------------------------------------------
	// Switching decision
	// ----------------------------------------------------------------
	logic               q_ff, nxt_q;
	logic signed [31:0] work_ff, nxt_work;

	always_comb begin
		nxt_q    = q_ff;
		nxt_work = work_ff;
		if (!en_ff) begin
			nxt_q = 1'b0;
		end else if (tick_ff) begin
			nxt_work = work;
			if (win_mode) begin
				nxt_q = (work >= on_x100) && (work < off_x100);
			end else if (work > on_x100) begin
				nxt_q = 1'b1;
			end else if (work <= off_x100) begin
				nxt_q = 1'b0;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q_ff    <= 1'b0;
			work_ff <= 32'sh00000000;
		end else begin
			q_ff    <= nxt_q;
			work_ff <= nxt_work;
		end
	end

	assign o_q = q_ff;

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	logic [31:0] rdata_ff, nxt_rdata;

	always_comb begin
		nxt_rdata = 32'h00000000;
		if (i_rd) begin
			unique case (i_addr)
				`ADT_REG_CTRL:     nxt_rdata = {31'h00000000, en_ff};
				`ADT_REG_GAIN:     nxt_rdata = 32'(gain_ff);
				`ADT_REG_OFFSET:   nxt_rdata = 32'(offset_ff);
				`ADT_REG_ON:       nxt_rdata = 32'(on_ff);
				`ADT_REG_DELTA:    nxt_rdata = 32'(delta_ff);
				`ADT_REG_DECIMALS: nxt_rdata = {30'h00000000, dec_ff};
				`ADT_REG_SOURCE:   nxt_rdata = {19'h00000, src_idx_ff, 5'h00, src_kind_ff};
				`ADT_REG_PERIOD:   nxt_rdata = {16'h0000, period_ff};
				`ADT_REG_STATUS:   nxt_rdata = {30'h00000000, win_mode, q_ff};
				`ADT_REG_WORK:     nxt_rdata = work_ff;
				`ADT_REG_OFF:      nxt_rdata = off_thr;
				default:           nxt_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_ff <= 32'h00000000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign o_rdata = rdata_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_b);

	logic signed [31:0] chk_work;

	always_comb begin
		chk_work = 32'(sel_x) * 32'(gain_ff) + 32'(offset_ff) * 32'sh00000064;
	end

	a_work_formula: assert property (tick_ff && en_ff |=> work_ff == $past(chk_work))
		else $error("working value does not match input times gain plus offset");
	a_scale_ranges: assert property ((gain_ff <= 16'sh03E8) && (gain_ff >= -16'sh03E8)
		&& (offset_ff <= 16'sh2710) && (offset_ff >= -16'sh2710))
		else $error("gain or offset outside its range");
	a_thr_ranges: assert property ((on_ff <= 16'sh4E20) && (on_ff >= -16'sh4E20)
		&& (delta_ff <= 16'sh4E20) && (delta_ff >= -16'sh4E20))
		else $error("threshold or differential outside its range");
	a_off_readback: assert property (i_rd && i_addr == `ADT_REG_OFF
		|=> $signed(o_rdata) == $past(on_ff) + $past(delta_ff))
		else $error("release threshold readback is not on plus differential");
	a_hyst_set: assert property (tick_ff && en_ff && !win_mode && work > on_x100 |=> o_q)
		else $error("output not set above switch threshold");
	a_hyst_clear: assert property (tick_ff && en_ff && !win_mode && work <= off_x100 && work <= on_x100
		|=> !o_q)
		else $error("output not cleared at or below release threshold");
	a_window_out: assert property (tick_ff && en_ff && win_mode |=>
		o_q == ($past(work) >= $past(on_x100) && $past(work) < $past(off_x100)))
		else $error("window output wrong");
	a_dec_range: assert property (i_wr && i_addr == `ADT_REG_DECIMALS && $signed(i_wdata) > 32'sh00000003
		|=> dec_ff == 2'h3)
		else $error("decimal places outside range");
	a_dec_ignored: assert property (i_wr && i_addr == `ADT_REG_DECIMALS && !tick_ff && en_ff |=> $stable(o_q))
		else $error("decimal places changed the output");
	a_flag_select: assert property (src_kind_ff == 3'h1 |-> sel_x == i_analog_flags[src_idx_ff[3:0]*16 +: 16])
		else $error("analog flag not selected");
	a_sensor_span: assert property (src_kind_ff == 3'h0 |-> sel_x >= 16'sh0000 && sel_x <= 16'sh03E8)
		else $error("sensor value outside 0 to 1000");
	a_hold_between: assert property (tick_ff && en_ff && !win_mode && work <= on_x100 && work > off_x100
		|=> $stable(o_q))
		else $error("output changed between thresholds");
	a_no_eval_idle: assert property (en_ff && !tick_ff && $past(en_ff) |=> $stable(o_q))
		else $error("output changed outside a program cycle");

	c_hyst_set: cover property (tick_ff && !win_mode ##1 o_q);
	c_hyst_clear: cover property (o_q && !win_mode ##1 !o_q);
	c_window_on: cover property (tick_ff && win_mode ##1 o_q);
	c_sensor_clamp: cover property (src_kind_ff == 3'h0 && sensor_raw > `ADT_SENSOR_MAX);

endmodule : adt_trigger
